// >>> logic/hrl_hex_pair.sv
// Purpose: Turns ASCII hex characters into bytes and flags each record start.
// Assumes: Characters arrive one per strobe; a colon restarts the pairing.
// Notes:   All outputs are registered; byte_vld, sof and bad_chr last one cycle, byte_val holds.
module hrl_hex_pair
  import hrl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Character input
  input  wire logic       chr_vld,
  input  wire logic [7:0] chr,
  // Byte output
  output logic            byte_vld,
  output logic [7:0]      byte_val,
  output logic            sof,
  output logic            bad_chr
);

  logic       half_q;
  logic [3:0] hi_q;
  logic [4:0] nib;
  logic       is_colon;

  assign nib      = hrl_hex_val(chr);
  assign is_colon = (chr == HRL_CHR_COLON);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_q   <= 1'b0;
      hi_q     <= 4'h0;
      byte_vld <= 1'b0;
      byte_val <= 8'h00;
      sof      <= 1'b0;
      bad_chr  <= 1'b0;
    end
    else
    begin
      byte_vld <= chr_vld & ~is_colon & ~nib[4] & half_q;
      sof      <= chr_vld & is_colon;
      bad_chr  <= chr_vld & ~is_colon & nib[4];
      if (chr_vld)
      begin
        // A colon or a stray character drops any half-built byte.
        half_q <= ~is_colon & ~nib[4] & ~half_q;
        if (!half_q)
          hi_q <= nib[3:0];
        else
          byte_val <= {hi_q, nib[3:0]};
      end
    end
  end

endmodule : hrl_hex_pair

// >>> logic/hrl_loader.sv
// Purpose: Decodes hex or binary partitioned object files into byte writes.
// Assumes: in_valid/in_byte are synchronous; start pulses before each file.
// Notes:   Hex data is held until its checksum is proven, then replayed.
//
// Contract
// - Hex record: colon, count, address, type prefix, then two-character checksum.
// - Type 00 record stores its data bytes at consecutive addresses.
// - Checksum is two's complement of the sum of all preceding record bytes.
// - End record (count 00, address 0000, type 01) terminates the load.
// - Type 02 gives segment base bits 4-19, kept for later data records.
// - Type 04 gives address bits 16-31, kept for later data records.
// - Address is linear<<16 plus segment<<4 plus record address field.
// - Extended records may come anywhere and affect only later data.
// - Type 03 and 05 records are accepted and otherwise ignored.
// - Requested output record size above 16 is clamped to 16.
// - Hex addresses above FFFFFFF are rejected.
// - Binary format must start with identifier byte A2.
// - The 75 header bytes after the identifier are skipped unread.
// - The 20-byte table of contents is skipped before the sections.
// - Section: 3-byte address, 2-byte length, then that many data bytes.
// - Final binary checksum byte is accepted without checking.
module hrl_loader
  import hrl_pkg::*;
#(
  parameter int BUF_DEPTH = 256
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Control
  input  wire logic        start,
  input  wire logic        fmt_bin,
  input  wire logic [7:0]  req_size,
  // Object file stream
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_byte,
  input  wire logic        in_last,
  output logic             in_ready,
  // Buffer memory writes
  output logic             wr_valid,
  output logic [31:0]      wr_addr,
  output logic [7:0]       wr_data,
  // Status
  output logic             load_done,
  output logic             err_chksum,
  output logic             err_range,
  output logic             err_format,
  output logic [7:0]       rec_size
);

  initial
  begin
    if (BUF_DEPTH != 256)
      $error("BUF_DEPTH must be 256 to hold any record");
  end

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Byte source
  // ----------------------------------------------------------------------
  hrl_state_t  state_q;
  hrl_state_t  state_d;
  logic        bin_q;
  logic        take;
  logic        p_vld;
  logic [7:0]  p_byte;
  logic        p_sof;
  logic        p_bad;
  logic        b_vld;
  logic [7:0]  b_val;
  logic [7:0]  sum;
  logic [7:0]  sum_next;
  logic        sum_ok;

  assign take = in_valid & in_ready;

  hrl_hex_pair u_pair (
    .clk      (core_clk),
    .rst_n    (rst_n_q),
    .chr_vld  (take & ~bin_q),
    .chr      (in_byte),
    .byte_vld (p_vld),
    .byte_val (p_byte),
    .sof      (p_sof),
    .bad_chr  (p_bad)
  );

  // Binary bytes bypass the pairer; hex bytes come one cycle late from it.
  assign b_vld = bin_q ? take : p_vld;
  assign b_val = bin_q ? in_byte : p_byte;

  hrl_sum8 u_sum (
    .clk   (core_clk),
    .rst_n (rst_n_q),
    .clr   (p_sof | start),
    .add   (b_vld & ~bin_q),
    .val   (b_val),
    .sum   (sum)
  );

  assign sum_next = sum + b_val;
  assign sum_ok   = (sum_next == 8'h00);

  // ----------------------------------------------------------------------
  // Record fields and held offsets
  // ----------------------------------------------------------------------
  logic [7:0]  cnt_q;
  logic [7:0]  idx_q;
  logic [7:0]  typ_q;
  logic [15:0] off_q;
  logic [15:0] seg_q;
  logic [15:0] lin_q;
  logic [32:0] base_q;
  logic        pend_sof_q;
  logic [7:0]  mem [BUF_DEPTH];
  logic [15:0] skip_q;
  logic [1:0]  fcnt_q;
  logic [23:0] badr_q;
  logic [15:0] blen_q;
  logic [32:0] abs_addr;
  logic [32:0] flush_addr;
  logic        flush_ok;
  logic        last_dat;
  logic [15:0] xval;
  logic        hex_end;

  // Composes the absolute address of the record's first byte.
  function automatic logic [32:0] hrl_compose(input logic [15:0] lin,
                                              input logic [15:0] seg,
                                              input logic [15:0] off);
    hrl_compose = {1'b0, lin, 16'h0000}
                + {13'h0000, seg, 4'h0}
                + {17'h00000, off};
  endfunction : hrl_compose

  assign abs_addr   = hrl_compose(lin_q, seg_q, off_q);
  assign flush_addr = base_q + {25'h0000000, idx_q};
  assign flush_ok   = (flush_addr <= HRL_MAX_ADDR);
  assign last_dat   = (idx_q == cnt_q - 8'h01);
  assign xval       = {mem[0], mem[1]};
  assign hex_end    = (typ_q == HRL_TYP_END);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_HUNT:  if (p_sof) state_d = ST_CNT;
      ST_CNT:   if (b_vld) state_d = ST_AHI;
      ST_AHI:   if (b_vld) state_d = ST_ALO;
      ST_ALO:   if (b_vld) state_d = ST_TYP;
      ST_TYP:   if (b_vld) state_d = (cnt_q == 8'h00) ? ST_SUM : ST_DAT;
      ST_DAT:   if (b_vld && last_dat) state_d = ST_SUM;
      ST_SUM:
        if (b_vld)
        begin
          if (!sum_ok)
            state_d = ST_HUNT;
          else if (hex_end)
            state_d = ST_DONE;
          else if (typ_q == HRL_TYP_DATA && cnt_q != 8'h00)
            state_d = ST_FLUSH;
          else
            state_d = ST_HUNT;
        end
      ST_FLUSH: if (last_dat) state_d = pend_sof_q ? ST_CNT : ST_HUNT;
      ST_BID:   if (b_vld) state_d = (b_val == HRL_BIN_ID) ? ST_BSKIP : ST_DONE;
      ST_BSKIP: if (b_vld && skip_q == 16'h0001) state_d = ST_BADR;
      ST_BADR:
        if (b_vld && in_last)
          state_d = ST_DONE;
        else if (b_vld && fcnt_q == HRL_BIN_ADR_LEN - 2'h1)
          state_d = ST_BLEN;
      ST_BLEN:
        if (b_vld && fcnt_q == HRL_BIN_LEN_LEN - 2'h1)
          state_d = ({b_val, blen_q[7:0]} == 16'h0000) ? ST_BADR : ST_BDAT;
      ST_BDAT:  if (b_vld && blen_q == 16'h0001) state_d = ST_BADR;
      ST_DONE:  state_d = ST_DONE;
      default:  state_d = ST_HUNT;
    endcase
    // A colon always restarts hex framing, except while replaying or once done.
    if (!bin_q && p_sof && state_q != ST_FLUSH && state_q != ST_DONE)
      state_d = ST_CNT;
    if (start)
      state_d = fmt_bin ? ST_BID : ST_HUNT;
  end

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q    <= ST_HUNT;
      bin_q      <= 1'b0;
      in_ready   <= 1'b0;
      pend_sof_q <= 1'b0;
      cnt_q      <= 8'h00;
      idx_q      <= 8'h00;
      typ_q      <= 8'h00;
      off_q      <= HRL_OFFS_RST;
      seg_q      <= HRL_OFFS_RST;
      lin_q      <= HRL_OFFS_RST;
      base_q     <= 33'h0_0000_0000;
      skip_q     <= 16'h0000;
      fcnt_q     <= 2'h0;
      badr_q     <= 24'h000000;
      blen_q     <= 16'h0000;
    end
    else
    begin
      state_q  <= state_d;
      // Input stalls while a proven record is replayed to memory.
      in_ready <= (state_d != ST_FLUSH);
      if (start)
      begin
        bin_q      <= fmt_bin;
        pend_sof_q <= 1'b0;
        seg_q      <= HRL_OFFS_RST;
        lin_q      <= HRL_OFFS_RST;
        skip_q     <= HRL_BIN_HDR_LEN + HRL_BIN_TOC_LEN;
        fcnt_q     <= 2'h0;
      end
      else
      begin
        // A colon caught in the cycle a replay of two or more bytes starts is kept, not lost.
        if (state_q == ST_FLUSH)
          pend_sof_q <= pend_sof_q | p_sof;
        else
          pend_sof_q <= 1'b0;
        if (b_vld)
        begin
          case (state_q)
            ST_CNT:  cnt_q <= b_val;
            ST_AHI:  off_q[15:8] <= b_val;
            ST_ALO:  off_q[7:0]  <= b_val;
            ST_TYP:
            begin
              typ_q <= b_val;
              idx_q <= 8'h00;
            end
            ST_DAT:
            begin
              mem[idx_q] <= b_val;
              idx_q      <= idx_q + 8'h01;
            end
            ST_SUM:
            begin
              idx_q  <= 8'h00;
              base_q <= abs_addr;
              // Offsets change only after their own record, so later data sees them.
              if (sum_ok && cnt_q == HRL_XADDR_COUNT && typ_q == HRL_TYP_XSEG)
                seg_q <= xval;
              if (sum_ok && cnt_q == HRL_XADDR_COUNT && typ_q == HRL_TYP_XLIN)
                lin_q <= xval;
            end
            ST_BSKIP: skip_q <= skip_q - 16'h0001;
            ST_BADR:
            begin
              badr_q <= {badr_q[15:0], b_val};
              fcnt_q <= (fcnt_q == HRL_BIN_ADR_LEN - 2'h1) ? 2'h0 : fcnt_q + 2'h1;
            end
            ST_BLEN:
            begin
              blen_q <= {blen_q[7:0], b_val};
              fcnt_q <= (fcnt_q == HRL_BIN_LEN_LEN - 2'h1) ? 2'h0 : fcnt_q + 2'h1;
            end
            ST_BDAT:
            begin
              blen_q <= blen_q - 16'h0001;
              badr_q <= badr_q + 24'h000001;
            end
            default: ;
          endcase
        end
        if (state_q == ST_FLUSH)
          idx_q <= idx_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic        hex_wr;
  logic        bin_wr;
  logic        sum_bad;
  logic        typ_bad;
  logic [7:0]  size_clamped;

  assign hex_wr  = (state_q == ST_FLUSH) & flush_ok;
  assign bin_wr  = (state_q == ST_BDAT) & b_vld;
  assign sum_bad = (state_q == ST_SUM) & b_vld & ~sum_ok;
  // Start-address records pass as accepted; unknown types are format errors.
  assign typ_bad = (state_q == ST_TYP) & b_vld & (b_val > HRL_TYP_SLIN);
  assign size_clamped = (req_size > HRL_REC_SIZE_MAX) ? HRL_REC_SIZE_MAX
                                                      : req_size;

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_valid   <= 1'b0;
      wr_addr    <= 32'h0000_0000;
      wr_data    <= 8'h00;
      load_done  <= 1'b0;
      err_chksum <= 1'b0;
      err_range  <= 1'b0;
      err_format <= 1'b0;
      rec_size   <= 8'h00;
    end
    else
    begin
      rec_size <= size_clamped;
      wr_valid <= hex_wr | bin_wr;
      if (hex_wr)
      begin
        wr_addr <= flush_addr[31:0];
        wr_data <= mem[idx_q];
      end
      else if (bin_wr)
      begin
        wr_addr <= {8'h00, badr_q};
        wr_data <= b_val;
      end
      if (start)
      begin
        load_done  <= 1'b0;
        err_chksum <= 1'b0;
        err_range  <= 1'b0;
        err_format <= 1'b0;
      end
      else
      begin
        load_done <= load_done | (state_d == ST_DONE);
        err_chksum <= err_chksum | sum_bad;
        err_range  <= err_range | ((state_q == ST_FLUSH) & ~flush_ok);
        err_format <= err_format | typ_bad | (p_bad & ~bin_q)
                    | ((state_q == ST_BID) & b_vld & (b_val != HRL_BIN_ID));
      end
    end
  end

endmodule : hrl_loader

// >>> logic/hrl_sum8.sv
// Purpose: Running modulo-256 sum of record bytes.
// Assumes: Clear and add never matter in the same cycle except a restart.
// Notes:   Clear wins, so the first byte after a restart starts a fresh sum.
module hrl_sum8
  import hrl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] val,
  // Result
  output logic [7:0]      sum
);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sum <= HRL_SUM_RST;
    else if (clr)
      sum <= HRL_SUM_RST;
    else if (add)
      sum <= sum + val;
  end

endmodule : hrl_sum8

// >>> shared/hrl_pkg.sv
// Purpose: Shared constants, state encoding and helpers for the hex record loader.
// Assumes: Byte-wide object file stream, one 20 MHz clock.
// Notes:   Format offsets and counts live here, with the offset and sum reset values.
package hrl_pkg;

  // ----------------------------------------------------------------------
  // Hexadecimal record format
  // ----------------------------------------------------------------------
  localparam logic [7:0]  HRL_CHR_COLON    = 8'h3A;
  localparam logic [7:0]  HRL_TYP_DATA     = 8'h00;
  localparam logic [7:0]  HRL_TYP_END      = 8'h01;
  localparam logic [7:0]  HRL_TYP_XSEG     = 8'h02;
  localparam logic [7:0]  HRL_TYP_SSEG     = 8'h03;
  localparam logic [7:0]  HRL_TYP_XLIN     = 8'h04;
  localparam logic [7:0]  HRL_TYP_SLIN     = 8'h05;
  localparam logic [7:0]  HRL_XADDR_COUNT  = 8'h02;
  localparam int          HRL_SEG_SHIFT    = 4;
  localparam int          HRL_LIN_SHIFT    = 16;
  localparam logic [32:0] HRL_MAX_ADDR     = 33'h0_0FFF_FFFF;
  localparam logic [7:0]  HRL_REC_SIZE_MAX = 8'h10;

  // ----------------------------------------------------------------------
  // Binary partitioned format
  // ----------------------------------------------------------------------
  localparam logic [7:0]  HRL_BIN_ID       = 8'hA2;
  localparam logic [15:0] HRL_BIN_HDR_LEN  = 16'h004B;
  localparam logic [15:0] HRL_BIN_TOC_LEN  = 16'h0014;
  localparam logic [1:0]  HRL_BIN_ADR_LEN  = 2'h3;
  localparam logic [1:0]  HRL_BIN_LEN_LEN  = 2'h2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] HRL_OFFS_RST     = 16'h0000;
  localparam logic [7:0]  HRL_SUM_RST      = 8'h00;

  // ----------------------------------------------------------------------
  // Decoder states
  // ----------------------------------------------------------------------
  typedef enum logic [13:0] {
    ST_HUNT  = 14'h0001,
    ST_CNT   = 14'h0002,
    ST_AHI   = 14'h0004,
    ST_ALO   = 14'h0008,
    ST_TYP   = 14'h0010,
    ST_DAT   = 14'h0020,
    ST_SUM   = 14'h0040,
    ST_FLUSH = 14'h0080,
    ST_BID   = 14'h0100,
    ST_BSKIP = 14'h0200,
    ST_BADR  = 14'h0400,
    ST_BLEN  = 14'h0800,
    ST_BDAT  = 14'h1000,
    ST_DONE  = 14'h2000
  } hrl_state_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bit 4 of the result flags a character that is not a hex digit.
  function automatic logic [4:0] hrl_hex_val(input logic [7:0] c);
    logic [4:0] v;
    v = 5'h10;
    if (c >= 8'h30 && c <= 8'h39)
      v = {1'b0, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      v = {1'b0, c[3:0] + 4'h9};
    return v;
  endfunction : hrl_hex_val

endpackage : hrl_pkg

// >>> testbench/hrl_host_model.sv
// Purpose: Host that streams object file bytes into the loader.
// Assumes: Tasks are entered 2 ns after a rising edge.
// Notes:   Idle lines toggle so a stale byte never looks valid.
module hrl_host_model
(
  // Clock and handshake
  input  wire logic       core_clk,
  input  wire logic       in_ready,
  // Stream
  output logic            in_valid,
  output logic [7:0]      in_byte,
  output logic            in_last
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    in_valid = 1'b0;
    in_byte  = 8'h00;
    in_last  = 1'b0;
  end

  // Holds the byte until it is taken; returns 2 ns after that edge.
  task automatic send(input logic [7:0] b, input logic l);
    in_valid = 1'b1;
    in_byte  = b;
    in_last  = l;
    @(posedge core_clk);
    while (in_ready !== 1'b1)
      @(posedge core_clk);
    #2;
  endtask : send

  task automatic idle(input int n);
    in_valid = 1'b0;
    in_last  = 1'b0;
    repeat (n)
    begin
      in_byte = ~in_byte;
      @(posedge core_clk);
      #2;
    end
  endtask : idle
endmodule : hrl_host_model

// >>> testbench/hrl_loader_props.sv
// Purpose: Port-level checks for the hex record loader.
// Assumes: One clock domain; resetn is active low.
// Notes:   Bound onto every loader instance after the module.
module hrl_loader_props
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Control and stream
  input wire logic        start,
  input wire logic        fmt_bin,
  input wire logic [7:0]  req_size,
  input wire logic        in_valid,
  input wire logic [7:0]  in_byte,
  input wire logic        in_ready,
  // Writes and status
  input wire logic        wr_valid,
  input wire logic [31:0] wr_addr,
  input wire logic        load_done,
  input wire logic        err_chksum,
  input wire logic        err_format,
  input wire logic [7:0]  rec_size
);
  timeunit 1ns;
  timeprecision 100ps;
  import hrl_pkg::*;

  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  // The edge count keeps the size check clear of the reset synchroniser.
  logic [1:0] up_q;
  logic       first_q;
  logic       bin_q;

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      up_q    <= 2'h0;
      first_q <= 1'b0;
      bin_q   <= 1'b0;
    end
    else
    begin
      up_q    <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
      first_q <= start | (first_q & ~(in_valid & in_ready));
      bin_q   <= start ? fmt_bin : bin_q;
    end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_bad_id;
    bin_q && first_q && in_valid && in_ready && in_byte != HRL_BIN_ID;
  endsequence

  sequence s_flag_soon;
    ##[1:3] err_format;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  size_clamp_a: assert property (up_q == 2'h3 |=> rec_size ==
    (($past(req_size) > HRL_REC_SIZE_MAX) ? HRL_REC_SIZE_MAX : $past(req_size)))
    else $error("rec_size not clamped");
  done_sticky_a: assert property (load_done && !start |=> load_done)
    else $error("load_done dropped");
  done_quiet_a: assert property (load_done |-> !wr_valid)
    else $error("write after end");
  chk_sticky_a: assert property (err_chksum && !start |=> err_chksum)
    else $error("err_chksum dropped");
  start_clear_a: assert property (start |=> !load_done && !err_chksum)
    else $error("start left status set");
  addr_limit_a: assert property (wr_valid |-> wr_addr <= HRL_MAX_ADDR[31:0])
    else $error("write above top address");
  addr_step_a: assert property (wr_valid ##1 wr_valid |-> wr_addr == $past(wr_addr) + 32'h1)
    else $error("write addresses not consecutive");
  bad_id_a: assert property (s_bad_id |-> s_flag_soon)
    else $error("bad binary id not flagged");
endmodule : hrl_loader_props

bind hrl_loader hrl_loader_props u_props
(
  .core_clk   (core_clk),
  .resetn     (resetn),
  .start      (start),
  .fmt_bin    (fmt_bin),
  .req_size   (req_size),
  .in_valid   (in_valid),
  .in_byte    (in_byte),
  .in_ready   (in_ready),
  .wr_valid   (wr_valid),
  .wr_addr    (wr_addr),
  .load_done  (load_done),
  .err_chksum (err_chksum),
  .err_format (err_format),
  .rec_size   (rec_size)
);

// >>> testbench/hrl_loader_test.sv
// Purpose: Self-checking bench for the hex record loader.
// Assumes: 20 MHz clock; inputs change 2 ns after the rising edge.
// Notes:   Ordinary records run from a table; odd cases follow by hand.
module hrl_loader_test;
  timeunit 1ns;
  timeprecision 100ps;
  import hrl_pkg::*;

  typedef struct packed {
    logic [7:0]  typ;
    logic [15:0] fld;
    logic [15:0] val;
    logic [31:0] exp;
  } hrl_row_t;

  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        start;
  logic        fmt_bin;
  logic [7:0]  req_size;
  logic        in_valid, in_last, in_ready, wr_valid;
  logic        load_done, err_chksum, err_range, err_format;
  logic [7:0]  in_byte, wr_data, rec_size;
  logic [31:0] wr_addr;
  logic [31:0] xa[$], wa[$];
  logic [7:0]  xd[$], wd[$];
  int          err_count = 0;
  int          check_count = 0;
  // Extended records carry ASCII zeros in the address field.
  hrl_row_t rows[10] = '{
    '{8'h04, 16'h0000, 16'h0010, 32'h0}, '{8'h02, 16'h0000, 16'h1230, 32'h0},
    '{8'h00, 16'h0045, 16'h55AA, 32'h0011_2345}, '{8'h03, 16'h0000, 16'h1234, 32'h0},
    '{8'h00, 16'h0046, 16'h0102, 32'h0011_2346}, '{8'h05, 16'h0000, 16'h5678, 32'h0},
    '{8'h02, 16'h0000, 16'h0000, 32'h0}, '{8'h00, 16'hFFFE, 16'h0304, 32'h0010_FFFE},
    '{8'h04, 16'h0000, 16'h0FFF, 32'h0}, '{8'h00, 16'hFFF0, 16'h0506, 32'h0FFF_FFF0}};
  logic [7:0] sects[13] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h02, 8'h5A, 8'h3C,
                            8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h77};
  logic [7:0] sz_in[4]  = '{8'h20, 8'h0C, 8'h10, 8'h11};

  always #25 core_clk = ~core_clk;

  always @(posedge core_clk)
    if (wr_valid === 1'b1)
    begin
      wa.push_back(wr_addr);
      wd.push_back(wr_data);
    end

  hrl_loader #(.BUF_DEPTH(256)) dut (
    .core_clk (core_clk), .resetn (resetn), .start (start), .fmt_bin (fmt_bin),
    .req_size (req_size), .in_valid (in_valid), .in_byte (in_byte), .in_last (in_last),
    .in_ready (in_ready), .wr_valid (wr_valid), .wr_addr (wr_addr), .wr_data (wr_data),
    .load_done (load_done), .err_chksum (err_chksum), .err_range (err_range),
    .err_format (err_format), .rec_size (rec_size));

  hrl_host_model host (
    .core_clk (core_clk), .in_ready (in_ready), .in_valid (in_valid),
    .in_byte (in_byte), .in_last (in_last));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  function automatic logic [7:0] asc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : asc

  task automatic send_hex(input logic [7:0] b);
    host.send(asc(b[7:4]), 1'b0);
    host.send(asc(b[3:0]), 1'b0);
  endtask : send_hex

  // A nonzero bad value spoils the checksum on purpose.
  task automatic send_rec(input logic [7:0] typ, input logic [15:0] fld,
                          input logic [15:0] val, input logic [7:0] cnt, input logic [7:0] bad);
    logic [7:0] s;
    s = cnt + fld[15:8] + fld[7:0] + typ + val[15:8] + val[7:0];
    host.send(HRL_CHR_COLON, 1'b0);
    send_hex(cnt);
    send_hex(fld[15:8]);
    send_hex(fld[7:0]);
    send_hex(typ);
    if (cnt == 8'h02)
    begin
      send_hex(val[15:8]);
      send_hex(val[7:0]);
    end
    send_hex(8'h00 - s + bad);
    host.idle(1);
  endtask : send_rec

  task automatic drain();
    int n;
    n = 0;
    while (wa.size() < xa.size() && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    #2;
    check("write count", 32'(xa.size()), 32'(wa.size()));
    foreach (xa[i])
      if (i < wa.size())
      begin
        check("wr_addr", xa[i], wa[i]);
        check("wr_data", 32'(xd[i]), 32'(wd[i]));
      end
    xa.delete();
    xd.delete();
    wa.delete();
    wd.delete();
  endtask : drain

  task automatic begin_file(input logic bin);
    fmt_bin = bin;
    start   = 1'b1;
    @(posedge core_clk);
    #2;
    start   = 1'b0;
  endtask : begin_file

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    start    = 1'b0;
    fmt_bin  = 1'b0;
    req_size = 8'h00;
    repeat (20) @(posedge core_clk);
    #2;
    check("idle status", 32'h0, 32'({in_ready, wr_valid, load_done, err_chksum}));
    resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    #2;
    begin_file(1'b0);
    foreach (rows[i])
    begin
      send_rec(rows[i].typ, rows[i].fld, rows[i].val, 8'h02, 8'h00);
      if (rows[i].typ == HRL_TYP_DATA)
      begin
        xa.push_back(rows[i].exp);
        xd.push_back(rows[i].val[15:8]);
        xa.push_back(rows[i].exp + 32'h1);
        xd.push_back(rows[i].val[7:0]);
      end
      drain();
    end
    check("err_format", 32'h0, 32'(err_format));
    send_rec(8'h00, 16'hFFFF, 16'hA5C3, 8'h02, 8'h00);
    xa.push_back(32'h0FFF_FFFF);
    xd.push_back(8'hA5);
    drain();
    check("err_range", 32'h1, 32'(err_range));
    send_rec(8'h00, 16'h0010, 16'h1122, 8'h02, 8'h01);
    drain();
    check("err_chksum", 32'h1, 32'(err_chksum));
    send_rec(HRL_TYP_END, 16'h0000, 16'h0000, 8'h00, 8'h00);
    send_rec(8'h00, 16'h0020, 16'h9988, 8'h02, 8'h00);
    drain();
    check("load_done", 32'h1, 32'(load_done));
    begin_file(1'b1);
    host.send(HRL_BIN_ID, 1'b0);
    repeat (75) host.send(8'h20, 1'b0);
    repeat (20) host.send(8'h00, 1'b0);
    foreach (sects[i])
      host.send(sects[i], 1'b0);
    host.send(8'h00, 1'b1);
    host.idle(1);
    xa = '{32'h10, 32'h11, 32'h100};
    xd = '{8'h5A, 8'h3C, 8'h77};
    drain();
    check("bin status", 32'h4, 32'({load_done, err_chksum, err_format}));
    begin_file(1'b1);
    host.send(8'h55, 1'b0);
    host.idle(4);
    check("err_format", 32'h1, 32'(err_format));
    foreach (sz_in[i])
    begin
      req_size = sz_in[i];
      repeat (2) @(posedge core_clk);
      #2;
      check("rec_size", (sz_in[i] > 8'h10) ? 32'h10 : 32'(sz_in[i]), 32'(rec_size));
    end
    close_out();
  end

  // Whole run is well under 3000 cycles; allow ten times that.
  initial
  begin
    #(50 * 30000);
    err_count++;
    $display("Error watchdog expected finish seen hang");
    close_out();
  end
endmodule : hrl_loader_test
